// [bench/lcdhi_host_model.sv]
// Host processor model driving the parallel and serial ports.
`timescale 1ns/1ps
module lcdhi_host_model (
    input wire logic mclk_i,
    input wire logic busy_i,
    input wire logic [7:0] rd_bus_i,
    input wire logic rd_oe_n_i,
    output logic port_select_pin_o,
    output logic e_o,
    output logic reg_or_data_select_o,
    output logic rw_o,
    output logic [7:0] db_o,
    output logic ser_cs_o,
    output logic ser_clk_o,
    output logic serial_data_in_o
);
    initial begin
        port_select_pin_o = 1'h1;
        e_o = 1'h0;
        reg_or_data_select_o = 1'h0;
        rw_o = 1'h0;
        db_o = 8'h00;
        ser_cs_o = 1'h0;
        ser_clk_o = 1'h0;
        serial_data_in_o = 1'h0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic set_port(input logic v);
        port_select_pin_o <= v;
        cyc(4);
    endtask

    // Waits with a bounded count until the previous instruction has finished.
    task automatic wait_idle();
        int k;
        k = 0;
        cyc(2);
        while (busy_i !== 1'h0 && k < 400) begin
            cyc(1);
            k++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // One enable strobe; the lines are held past the fall, then the data lines show the inverse.
    task automatic strobe(input logic sel, input logic rw, input logic [7:0] v);
        reg_or_data_select_o <= sel;
        rw_o <= rw;
        db_o <= v;
        cyc(1);
        e_o <= 1'h1;
        cyc(5);
        e_o <= 1'h0;
        cyc(4);
        db_o <= ~v;
        cyc(1);
    endtask

    task automatic par_write(input logic sel, input logic [7:0] b, input logic four,
                             input logic wt);
        if (four) begin
            strobe(sel, 1'h0, {b[7:4], 4'h5});
            strobe(sel, 1'h0, {b[3:0], 4'h5});
        end else begin
            strobe(sel, 1'h0, b);
        end
        if (wt) begin
            wait_idle();
        end
    endtask

    task automatic par_read(input logic sel, output logic [7:0] d, output logic oe_n);
        reg_or_data_select_o <= sel;
        rw_o <= 1'h1;
        cyc(1);
        e_o <= 1'h1;
        cyc(6);
        d = rd_bus_i;
        oe_n = rd_oe_n_i;
        e_o <= 1'h0;
        cyc(4);
        rw_o <= 1'h0;
        cyc(1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Serial bit: data set while the clock is low, clock parked low after it.
    task automatic ser_bit(input logic b);
        serial_data_in_o <= b;
        cyc(4);
        ser_clk_o <= 1'h1;
        cyc(4);
        ser_clk_o <= 1'h0;
    endtask

    // Sends the first n bits of a frame, then deselects with clock and data still.
    task automatic ser_frame(input logic rw, input logic sel, input logic [7:0] b,
                             input int n);
        logic [26:0] f;
        f = {5'h1F, rw, sel, 4'h0, b[7:4], 4'h0, b[3:0], 4'h0};
        ser_cs_o <= 1'h1;
        cyc(2);
        for (int i = 26; i > 26 - n; i--) begin
            ser_bit(f[i]);
        end
        cyc(4);
        ser_cs_o <= 1'h0;
        cyc(4);
        wait_idle();
    endtask

    // Sends a whole write frame with the select left high, as if tied high.
    task automatic ser_tied(input logic sel, input logic [7:0] b);
        logic [26:0] f;
        f = {5'h1F, 1'h0, sel, 4'h0, b[7:4], 4'h0, b[3:0], 4'h0};
        ser_cs_o <= 1'h1;
        for (int i = 26; i >= 0; i--) begin
            ser_bit(f[i]);
        end
        wait_idle();
    endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench of the LCD host interface.
`timescale 1ns/1ps
`include "lcdhi_defs.svh"
module tb_top;
    logic mclk_i, arst_n_i, psel, e, sel, rw, oe_n, cs, sclk, sdat;
    logic cmd_v, ram_we, gset, width, ext, busy, o_n;
    logic [7:0] hdb, dwire, ddb, rdd, cmd_b, wdat, d;
    logic [`LCDHI_AC_W-1:0] addr;
    logic [`LCDHI_VERT_W-1:0] vert;
    logic [`LCDHI_HORZ_W-1:0] horz;
    int miscompares = 0;
    int tests_run = 0;
    int n_cmd = 0;
    int n_we = 0;
    int cycles = 0;

    assign dwire = (oe_n == 1'h0) ? ddb : hdb;

    lcdhi_top #(.EXEC_CYC(20)) DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .port_select_pin_i(psel), .e_i(e), .reg_or_data_select_i(sel), .rw_i(rw),
        .db_i(dwire), .db_o(ddb), .db_oe_n_o(oe_n), .ser_cs_i(cs), .ser_clk_i(sclk),
        .serial_data_in_i(sdat), .rd_data_i(rdd), .cmd_valid_o(cmd_v),
        .cmd_byte_o(cmd_b), .ram_we_o(ram_we), .ram_wdata_o(wdat),
        .addr_counter_o(addr), .gfx_vert_o(vert), .gfx_horz_o(horz),
        .gfx_addr_set_o(gset), .bus_width_bit_o(width), .ext_set_o(ext),
        .busy_indication_o(busy));

    lcdhi_host_model host (.mclk_i(mclk_i), .busy_i(busy), .rd_bus_i(dwire),
        .rd_oe_n_i(oe_n), .port_select_pin_o(psel), .e_o(e),
        .reg_or_data_select_o(sel), .rw_o(rw), .db_o(hdb), .ser_cs_o(cs),
        .ser_clk_o(sclk), .serial_data_in_o(sdat));

    initial begin
        mclk_i = 1'h0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("counts: %0d checks, %0d mismatches", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Counts the one-cycle pulses and cuts a hang short.
    always @(posedge mclk_i) begin
        cycles++;
        if (cmd_v === 1'h1) n_cmd++;
        if (ram_we === 1'h1) n_we++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rdd = 8'hA5;
        arst_n_i = 1'h0;
        repeat (4) @(posedge mclk_i);
        arst_n_i <= 1'h1;
        repeat (3) @(posedge mclk_i);
        check("busy", {7'h0, busy}, 8'h00);
        check("width", {7'h0, width}, 8'h01);
        check("ext", {7'h0, ext}, 8'h00);
        check("oe_n", {7'h0, oe_n}, 8'h01);
        $display("test reset done");
        host.par_write(1'h0, 8'h30, 1'h0, 1'h0);
        check("busy", {7'h0, busy}, 8'h01);
        host.par_write(1'h0, 8'h01, 1'h0, 1'h1);
        check("cmd", cmd_b, 8'h30);
        check("cmd count", 8'(n_cmd), 8'h01);
        $display("test busy done");
        host.par_write(1'h0, 8'h34, 1'h0, 1'h1);
        check("ext", {7'h0, ext}, 8'h01);
        host.par_write(1'h0, 8'hFF, 1'h0, 1'h1);
        host.par_write(1'h0, 8'h8E, 1'h0, 1'h1);
        check("vert", {2'h0, vert}, 8'h3F);
        check("horz", {4'h0, horz}, 8'h0E);
        check("gset", {7'h0, gset}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            host.par_write(1'h1, 8'h10 + 8'(i), 1'h0, 1'h1);
            if (i == 1) check("horz", {4'h0, horz}, 8'h0F);
        end
        check("horz", {4'h0, horz}, 8'h00);
        check("vert", {2'h0, vert}, 8'h3F);
        check("wdata", wdat, 8'h13);
        check("we count", 8'(n_we), 8'h04);
        $display("test graphic done");
        host.par_read(1'h0, d, o_n);
        check("status", d, 8'h00);
        check("oe_n", {7'h0, o_n}, 8'h00);
        host.par_read(1'h1, d, o_n);
        check("ram read", d, 8'hA5);
        check("oe_n", {7'h0, oe_n}, 8'h01);
        $display("test read done");
        host.par_write(1'h0, 8'h24, 1'h0, 1'h1);
        check("width", {7'h0, width}, 8'h00);
        host.par_write(1'h0, 8'h20, 1'h1, 1'h1);
        check("ext", {7'h0, ext}, 8'h00);
        host.par_write(1'h0, 8'h01, 1'h1, 1'h1);
        check("cmd", cmd_b, 8'h01);
        host.par_write(1'h1, 8'hC3, 1'h1, 1'h1);
        check("wdata", wdat, 8'hC3);
        host.par_write(1'h1, 8'h3C, 1'h1, 1'h1);
        check("wdata", wdat, 8'h3C);
        check("addr", {1'h0, addr}, 8'h01);
        host.par_write(1'h0, 8'h04, 1'h1, 1'h1);
        host.par_write(1'h1, 8'h11, 1'h1, 1'h1);
        host.par_write(1'h1, 8'h22, 1'h1, 1'h1);
        check("addr", {1'h0, addr}, 8'h00);
        check("cmd count", 8'(n_cmd), 8'h08);
        host.par_read(1'h1, d, o_n);
        check("ram read", d, 8'hA0);
        host.par_read(1'h1, d, o_n);
        check("ram read", d, 8'h50);
        $display("test nibble done");
        host.set_port(1'h0);
        host.par_write(1'h1, 8'h77, 1'h0, 1'h1);
        check("we count", 8'(n_we), 8'h08);
        host.ser_frame(1'h0, 1'h0, 8'h34, 27);
        check("cmd", cmd_b, 8'h34);
        check("ext", {7'h0, ext}, 8'h01);
        host.ser_frame(1'h0, 1'h1, 8'hA6, 27);
        check("wdata", wdat, 8'hA6);
        host.ser_frame(1'h1, 1'h0, 8'h55, 27);
        check("cmd", cmd_b, 8'h34);
        check("cmd count", 8'(n_cmd), 8'h09);
        host.ser_frame(1'h0, 1'h1, 8'hFF, 14);
        host.ser_frame(1'h0, 1'h1, 8'h69, 27);
        check("wdata", wdat, 8'h69);
        check("we count", 8'(n_we), 8'h0A);
        $display("test serial done");
        host.ser_tied(1'h1, 8'h5A);
        check("wdata", wdat, 8'h5A);
        host.ser_tied(1'h1, 8'hC7);
        check("wdata", wdat, 8'hC7);
        check("we count", 8'(n_we), 8'h0C);
        $display("test tied select done");
        final_report();
    end
endmodule

// [logic/lcdhi_defs.svh]
// Constants of the LCD host interface: counts, field positions and timing.
// Notes on behaviour
// - Graphic address takes two bytes: vertical, horizontal.
// - Vertical address six bits, horizontal four bits.
// - Horizontal address auto-increments, wraps, vertical unchanged.
// - Port select high parallel, low serial.
// - Width bit picks 8-bit or 4-bit bus.
// - Host drives select, direction, strobe, data lines.
// - 4-bit mode: upper nibble first on upper lines.
// - Serial link uses select, host clock and data.
// - Serial port accepts writes only, never reads.
// - Select low clears bit counter and shift register.
// - Serial clock asynchronous, synchronised before use.
// - Five ones resynchronise the serial transfer counter.
// - Start byte: ones, direction, select, four zeros.
// - Each byte sent as two nibble sections.
// - Data write stores byte, then steps counter; the code steps it only on every second data write.
// - While busy, new instructions are not accepted.
`ifndef LCDHI_DEFS_SVH
`define LCDHI_DEFS_SVH
`define LCDHI_CLK_MHZ 40
`define LCDHI_EXEC_NS 2000
`define LCDHI_EXEC_CYC ((`LCDHI_EXEC_NS * `LCDHI_CLK_MHZ + 999) / 1000)
`define LCDHI_SYNC_RUN 3'h4
`define LCDHI_HDR_LAST 3'h5
`define LCDHI_NIB_LAST 3'h3
`define LCDHI_SECT_LAST 3'h7
`define LCDHI_AC_W 7
`define LCDHI_VERT_W 6
`define LCDHI_HORZ_W 4
`define LCDHI_OP_CLEAR 8'h01
`define LCDHI_FN_DL_BIT 4
`define LCDHI_FN_RE_BIT 2
`define LCDHI_EM_ID_BIT 1
`define LCDHI_BUSY_W 13
`endif

// [logic/lcdhi_pkg.sv]
// Types shared by the LCD host interface modules.
package lcdhi_pkg;
    typedef enum logic [1:0] {
        LCDHI_SER_HUNT,
        LCDHI_SER_HDR,
        LCDHI_SER_HI,
        LCDHI_SER_LO
    } lcdhi_ser_st_t;
endpackage

// [logic/lcdhi_ser_rx.sv]
// Serial write-only receiver of the LCD host interface.
`timescale 1ns/1ps
`include "lcdhi_defs.svh"
module lcdhi_ser_rx (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    input wire logic cs_i,
    input wire logic sclk_i,
    input wire logic serial_data_in_i,
    output logic byte_valid_o,
    output logic [7:0] byte_o,
    output logic rs_o
);
    logic cs_q1, cs_q2, ck_q1, ck_q2, ck_q3, sd_q1, sd_q2;
    logic rise, active;
    lcdhi_pkg::lcdhi_ser_st_t st_r, st_nxt;
    logic [2:0] cnt_r, cnt_nxt, run_r, run_nxt;
    logic [7:0] sh_r, sh_nxt, byte_nxt;
    logic [3:0] hi_r, hi_nxt;
    logic rw_r, rw_nxt, rs_nxt, valid_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the serial clock edge is found on the second stage.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {cs_q1, cs_q2, ck_q1, ck_q2, ck_q3, sd_q1, sd_q2} <= 7'h00;
        end else begin
            cs_q1 <= cs_i;
            cs_q2 <= cs_q1;
            ck_q1 <= sclk_i;
            ck_q2 <= ck_q1;
            ck_q3 <= ck_q2;
            sd_q1 <= serial_data_in_i;
            sd_q2 <= sd_q1;
        end
    end

    assign rise = ck_q2 & ~ck_q3;
    assign active = en_i & cs_q2;

    ////////////////////////////////////////////////////////////////////////
    // Start byte and section decoding.
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        sh_nxt = sh_r;
        hi_nxt = hi_r;
        rw_nxt = rw_r;
        rs_nxt = rs_o;
        byte_nxt = byte_o;
        valid_nxt = 1'b0;
        if (!active) begin
            st_nxt = lcdhi_pkg::LCDHI_SER_HUNT;
            cnt_nxt = 3'h0;
            run_nxt = 3'h0;
            sh_nxt = 8'h00;
        end else if (rise) begin
            sh_nxt = {sh_r[6:0], sd_q2};
            run_nxt = !sd_q2 ? 3'h0 : (run_r == 3'h7) ? run_r : 3'(run_r + 3'h1);
            cnt_nxt = 3'(cnt_r + 3'h1);
            if (sd_q2 && run_r == `LCDHI_SYNC_RUN && st_r != lcdhi_pkg::LCDHI_SER_HDR) begin
                st_nxt = lcdhi_pkg::LCDHI_SER_HDR;
                cnt_nxt = 3'h0;
            end else begin
                unique case (st_r)
                    lcdhi_pkg::LCDHI_SER_HUNT: begin
                        cnt_nxt = 3'h0;
                    end
                    lcdhi_pkg::LCDHI_SER_HDR: begin
                        if (cnt_r == 3'h0) begin
                            rw_nxt = sd_q2;
                        end
                        if (cnt_r == 3'h1) begin
                            rs_nxt = sd_q2;
                        end
                        if (cnt_r == `LCDHI_HDR_LAST) begin
                            st_nxt = lcdhi_pkg::LCDHI_SER_HI;
                            cnt_nxt = 3'h0;
                        end
                    end
                    lcdhi_pkg::LCDHI_SER_HI: begin
                        if (cnt_r == `LCDHI_NIB_LAST) begin
                            hi_nxt = {sh_r[2:0], sd_q2};
                        end
                        if (cnt_r == `LCDHI_SECT_LAST) begin
                            st_nxt = lcdhi_pkg::LCDHI_SER_LO;
                        end
                    end
                    lcdhi_pkg::LCDHI_SER_LO: begin
                        if (cnt_r == `LCDHI_SECT_LAST) begin
                            st_nxt = lcdhi_pkg::LCDHI_SER_HI;
                            byte_nxt = {hi_r, sh_r[6:3]};
                            valid_nxt = !rw_r;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= lcdhi_pkg::LCDHI_SER_HUNT;
            cnt_r <= 3'h0;
            run_r <= 3'h0;
            sh_r <= 8'h00;
            hi_r <= 4'h0;
            rw_r <= 1'b0;
            rs_o <= 1'b0;
            byte_o <= 8'h00;
            byte_valid_o <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            sh_r <= sh_nxt;
            hi_r <= hi_nxt;
            rw_r <= rw_nxt;
            rs_o <= rs_nxt;
            byte_o <= byte_nxt;
            byte_valid_o <= valid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_five_ones;
        active && rise && sd_q2 && run_r == 3'h4 && st_r != lcdhi_pkg::LCDHI_SER_HDR;
    endsequence

    sequence s_last_low;
        active && rise && st_r == lcdhi_pkg::LCDHI_SER_LO && cnt_r == 3'h7 && !rw_r;
    endsequence

    chk_cs_clear: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        !cs_q2 |=> cnt_r == 3'h0 && sh_r == 8'h00 && st_r == lcdhi_pkg::LCDHI_SER_HUNT)
        else $error("Serial state not cleared while deselected.");

    chk_sync_start: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        s_five_ones |=> st_r == lcdhi_pkg::LCDHI_SER_HDR && cnt_r == 3'h0)
        else $error("Five ones did not restart the header.");

    chk_no_read: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        byte_valid_o |-> !rw_r)
        else $error("Serial read transfer produced a byte.");

    chk_byte_emit: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        s_last_low |=> byte_valid_o ##1 !byte_valid_o)
        else $error("Serial byte not emitted as one pulse.");
endmodule

// [logic/lcdhi_top.sv]
// Host port front end of the LCD controller: parallel and serial ports.
`timescale 1ns/1ps
`include "lcdhi_defs.svh"
module lcdhi_top #(
    parameter int EXEC_CYC = `LCDHI_EXEC_CYC
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic port_select_pin_i,
    input wire logic e_i,
    input wire logic reg_or_data_select_i,
    input wire logic rw_i,
    input wire logic [7:0] db_i,
    output logic [7:0] db_o,
    output logic db_oe_n_o,
    input wire logic ser_cs_i,
    input wire logic ser_clk_i,
    input wire logic serial_data_in_i,
    input wire logic [7:0] rd_data_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_byte_o,
    output logic ram_we_o,
    output logic [7:0] ram_wdata_o,
    output logic [`LCDHI_AC_W-1:0] addr_counter_o,
    output logic [`LCDHI_VERT_W-1:0] gfx_vert_o,
    output logic [`LCDHI_HORZ_W-1:0] gfx_horz_o,
    output logic gfx_addr_set_o,
    output logic bus_width_bit_o,
    output logic ext_set_o,
    output logic busy_indication_o
);
    logic [11:0] pin_q1, pin_q2;
    logic e_q3;
    logic par_mode, e_s, rs_s, rw_s, e_fall;
    logic [7:0] db_s;
    logic ser_valid, ser_rs;
    logic [7:0] ser_byte;

    logic byte_ev, byte_rs, byte_rw, accept;
    logic [7:0] byte_val, rd_val;
    logic nib_r, nib_nxt;
    logic [3:0] hold_r, hold_nxt;
    logic pair_r, pair_nxt;
    logic gph_r, gph_nxt;
    logic inc_r, inc_nxt;
    logic [`LCDHI_BUSY_W-1:0] busy_cnt_r, busy_cnt_nxt;
    logic [7:0] db_nxt, cmd_byte_nxt, wdata_nxt;
    logic oe_n_nxt, cmd_valid_nxt, we_nxt;
    logic [`LCDHI_AC_W-1:0] ac_nxt;
    logic [`LCDHI_VERT_W-1:0] vert_nxt;
    logic [`LCDHI_HORZ_W-1:0] horz_nxt;
    logic gset_nxt, dl_nxt, re_nxt, busy_nxt;

    // Places a nibble on the upper data lines, lower lines driven low.
    function automatic logic [7:0] upper_lines(input logic [3:0] nib);
        upper_lines = {nib, 4'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Parallel pin synchronisers and strobe edge detection.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_q1 <= 12'h000;
            pin_q2 <= 12'h000;
            e_q3 <= 1'b0;
        end else begin
            pin_q1 <= {port_select_pin_i, e_i, reg_or_data_select_i, rw_i, db_i};
            pin_q2 <= pin_q1;
            e_q3 <= pin_q2[10];
        end
    end

    assign par_mode = pin_q2[11];
    assign e_s = pin_q2[10];
    assign rs_s = pin_q2[9];
    assign rw_s = pin_q2[8];
    assign db_s = pin_q2[7:0];
    assign e_fall = e_q3 & ~e_s;

    ////////////////////////////////////////////////////////////////////////
    // Serial receiver, only listening while the port select is low.
    lcdhi_ser_rx u_ser (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .en_i(~par_mode),
        .cs_i(ser_cs_i),
        .sclk_i(ser_clk_i),
        .serial_data_in_i(serial_data_in_i),
        .byte_valid_o(ser_valid),
        .byte_o(ser_byte),
        .rs_o(ser_rs)
    );

    ////////////////////////////////////////////////////////////////////////
    // Byte assembly, read drive, instruction decode and address counter.
    always_comb begin
        byte_ev = 1'b0;
        byte_rs = 1'b0;
        byte_rw = 1'b0;
        byte_val = 8'h00;
        nib_nxt = nib_r;
        hold_nxt = hold_r;
        pair_nxt = pair_r;
        gph_nxt = gph_r;
        inc_nxt = inc_r;
        ac_nxt = addr_counter_o;
        vert_nxt = gfx_vert_o;
        horz_nxt = gfx_horz_o;
        gset_nxt = gfx_addr_set_o;
        dl_nxt = bus_width_bit_o;
        re_nxt = ext_set_o;
        cmd_valid_nxt = 1'b0;
        cmd_byte_nxt = cmd_byte_o;
        we_nxt = 1'b0;
        wdata_nxt = ram_wdata_o;
        busy_cnt_nxt = (busy_cnt_r != '0) ? `LCDHI_BUSY_W'(busy_cnt_r - 1'b1) : busy_cnt_r;
        if (par_mode && e_fall) begin
            byte_rs = rs_s;
            byte_rw = rw_s;
            if (bus_width_bit_o) begin
                byte_ev = 1'b1;
                byte_val = db_s;
            end else if (!nib_r) begin
                nib_nxt = 1'b1;
                hold_nxt = db_s[7:4];
            end else begin
                nib_nxt = 1'b0;
                byte_ev = 1'b1;
                byte_val = {hold_r, db_s[7:4]};
            end
        end else if (!par_mode && ser_valid) begin
            byte_ev = 1'b1;
            byte_rs = ser_rs;
            byte_val = ser_byte;
        end
        if (!par_mode) begin
            nib_nxt = 1'b0;
        end
        rd_val = rs_s ? rd_data_i : {busy_indication_o, addr_counter_o};
        oe_n_nxt = !(par_mode && e_s && rw_s);
        db_nxt = bus_width_bit_o ? rd_val : upper_lines(nib_r ? rd_val[3:0] : rd_val[7:4]);
        accept = byte_ev && !byte_rw && busy_cnt_r == '0;
        if (accept) begin
            busy_cnt_nxt = `LCDHI_BUSY_W'(EXEC_CYC);
            if (byte_rs) begin
                we_nxt = 1'b1;
                wdata_nxt = byte_val;
                pair_nxt = !pair_r;
                if (pair_r && gfx_addr_set_o) begin
                    horz_nxt = `LCDHI_HORZ_W'(gfx_horz_o + 1'b1);
                end else if (pair_r) begin
                    ac_nxt = inc_r ? `LCDHI_AC_W'(addr_counter_o + 1'b1)
                                   : `LCDHI_AC_W'(addr_counter_o - 1'b1);
                end
            end else begin
                cmd_valid_nxt = 1'b1;
                cmd_byte_nxt = byte_val;
                gph_nxt = 1'b0;
                if (byte_val[7] && ext_set_o) begin
                    pair_nxt = 1'b0;
                    if (!gph_r) begin
                        vert_nxt = byte_val[`LCDHI_VERT_W-1:0];
                        gph_nxt = 1'b1;
                        gset_nxt = 1'b0;
                    end else begin
                        horz_nxt = byte_val[`LCDHI_HORZ_W-1:0];
                        gset_nxt = 1'b1;
                    end
                end else if (byte_val[7]) begin
                    ac_nxt = byte_val[`LCDHI_AC_W-1:0];
                    gset_nxt = 1'b0;
                    pair_nxt = 1'b0;
                end else if (byte_val[7:5] == 3'h1) begin
                    dl_nxt = byte_val[`LCDHI_FN_DL_BIT];
                    re_nxt = byte_val[`LCDHI_FN_RE_BIT];
                end else if (!ext_set_o && byte_val[7:2] == 6'h01) begin
                    inc_nxt = byte_val[`LCDHI_EM_ID_BIT];
                end else if (!ext_set_o && byte_val == `LCDHI_OP_CLEAR) begin
                    ac_nxt = '0;
                    inc_nxt = 1'b1;
                    gset_nxt = 1'b0;
                    pair_nxt = 1'b0;
                end else if (!ext_set_o && byte_val[7:1] == 7'h01) begin
                    ac_nxt = '0;
                    gset_nxt = 1'b0;
                    pair_nxt = 1'b0;
                end
            end
        end
        busy_nxt = busy_cnt_nxt != '0;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            nib_r <= 1'b0;
            hold_r <= 4'h0;
            pair_r <= 1'b0;
            gph_r <= 1'b0;
            inc_r <= 1'b1;
            busy_cnt_r <= '0;
            db_o <= 8'h00;
            db_oe_n_o <= 1'b1;
            cmd_valid_o <= 1'b0;
            cmd_byte_o <= 8'h00;
            ram_we_o <= 1'b0;
            ram_wdata_o <= 8'h00;
            addr_counter_o <= '0;
            gfx_vert_o <= '0;
            gfx_horz_o <= '0;
            gfx_addr_set_o <= 1'b0;
            bus_width_bit_o <= 1'b1;
            ext_set_o <= 1'b0;
            busy_indication_o <= 1'b0;
        end else begin
            nib_r <= nib_nxt;
            hold_r <= hold_nxt;
            pair_r <= pair_nxt;
            gph_r <= gph_nxt;
            inc_r <= inc_nxt;
            busy_cnt_r <= busy_cnt_nxt;
            db_o <= db_nxt;
            db_oe_n_o <= oe_n_nxt;
            cmd_valid_o <= cmd_valid_nxt;
            cmd_byte_o <= cmd_byte_nxt;
            ram_we_o <= we_nxt;
            ram_wdata_o <= wdata_nxt;
            addr_counter_o <= ac_nxt;
            gfx_vert_o <= vert_nxt;
            gfx_horz_o <= horz_nxt;
            gfx_addr_set_o <= gset_nxt;
            bus_width_bit_o <= dl_nxt;
            ext_set_o <= re_nxt;
            busy_indication_o <= busy_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_gfx_first;
        accept && !byte_rs && byte_val[7] && ext_set_o && !gph_r;
    endsequence

    sequence s_gfx_second;
        accept && !byte_rs && byte_val[7] && ext_set_o && gph_r;
    endsequence

    sequence s_wrap_write;
        accept && byte_rs && pair_r && gfx_addr_set_o && gfx_horz_o == 4'hF;
    endsequence

    chk_vert_load: assert property (
        s_gfx_first |=> gfx_vert_o == cmd_byte_o[5:0] && !gfx_addr_set_o)
        else $error("Vertical graphic address not loaded.");

    chk_horz_load: assert property (
        s_gfx_second |=> gfx_horz_o == cmd_byte_o[3:0] && gfx_addr_set_o)
        else $error("Horizontal graphic address not loaded.");

    chk_horz_wrap: assert property (
        s_wrap_write |=> gfx_horz_o == 4'h0 && $stable(gfx_vert_o))
        else $error("Horizontal address did not wrap alone.");

    chk_serial_quiet: assert property (
        !par_mode |=> db_oe_n_o)
        else $error("Data lines driven in serial mode.");

    chk_fall_capture: assert property (
        par_mode && bus_width_bit_o && e_fall && !rw_s && !rs_s && busy_cnt_r == '0
        |=> cmd_valid_o && cmd_byte_o == $past(db_s))
        else $error("Instruction not captured at strobe fall.");

    chk_nibble_first: assert property (
        par_mode && !bus_width_bit_o && e_fall && !nib_r |=> nib_r && !cmd_valid_o && !ram_we_o)
        else $error("First nibble completed a byte.");

    chk_busy_drop: assert property (
        byte_ev && busy_cnt_r != '0 |=> !ram_we_o && !cmd_valid_o)
        else $error("Transfer accepted while busy.");

    chk_busy_hold: assert property (
        cmd_valid_o |-> busy_indication_o [*8])
        else $error("Busy indication too short.");
endmodule
